/* src/sysconf_defines.svh */
// Register offsets, field positions, reset values and rule summary for the config block
// Behaviour
// [RQ1] The DMA priority bit set gives DMA SRAM requests precedence, cleared puts DMA in round robin.
// [RQ2] The CPU interrupt priority bit set gives the CPU precedence while in an interrupt, else round robin.
// [RQ3] The capture timebase bit set picks the alternate timer pair for capture, else timer 2/3.
// [RQ4] The compare timebase bit set picks the alternate timer pair for compare, else timer 2/3.
// [RQ5] The pin-routing lock bit set refuses writes to the pin routing registers.
// [RQ6] The module-disable lock bit set refuses writes to the module disable registers.
// [RQ7] The permission-group lock bit set refuses writes to the permission group registers.
// [RQ8] The USB sleep bit set stops the USB PHY clock while sleep is active.
// [RQ9] Configuration bits change only after the unlock sequence has been completed.
// [RQ10] Unimplemented bits of the configuration register always read zero.
// [RQ11] The identification register is read-only with revision in 31:28 and device code in 27:0.
// [RQ12] Two read-only serial words, index 0 and 1, return the 64-bit unique serial number.
// [RQ13] Writes to read-only registers or blocked by lock or missing unlock are silently ignored.
`ifndef SYSCONF_DEFINES_SVH
`define SYSCONF_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFF_CONFIG 8'h00
`define OFF_DEVCODE 8'h04
`define OFF_SERIAL0 8'h08
`define OFF_SERIAL1 8'h0c
`define OFF_UNLOCK 8'h10
`define OFF_ROUTE 8'h14
`define OFF_MODDIS 8'h18
`define OFF_PERMGRP 8'h1c
`define OFF_STATUS 8'h20

// ----------------------------------------
// Configuration field positions and masks
// ----------------------------------------
`define BIT_DMA_PRI 25
`define BIT_CPU_PRI 24
`define BIT_CAP_ALT 17
`define BIT_CMP_ALT 16
`define BIT_ROUTE_LOCK 13
`define BIT_MODDIS_LOCK 12
`define BIT_PERM_LOCK 11
`define BIT_USB_STOP 8
`define CONFIG_MASK 32'h03033900
`define CONFIG_RESET 32'h00000000

// ----------------------------------------
// Unlock keys and reset values
// ----------------------------------------
`define UNLOCK_KEY1 32'haa996655
`define UNLOCK_KEY2 32'h556699aa
`define GUARDED_RESET 32'h00000000
`define AXI_OKAY 2'h0

`endif

/* src/sysconf_pkg.sv */
// Types shared by the configuration register block
package sysconf_pkg;

  // Unlock sequence progress
  typedef enum logic [1:0] {
    unl_idle,
    unl_key1,
    unl_open
  } unlock_state_t;

  // Decoded configuration controls
  typedef struct packed {
    logic dma_sram_priority;
    logic cpu_irq_sram_priority;
    logic capture_alt_timebase;
    logic compare_alt_timebase;
    logic pin_route_lock;
    logic module_disable_lock;
    logic perm_group_lock;
    logic usb_sleep_clock_stop;
  } config_ctl_t;

  // SRAM requests from the three initiators
  typedef struct packed {
    logic dma;
    logic cpu;
    logic other;
  } sram_req_t;

endpackage : sysconf_pkg

/* src/sysconf_regs.sv */
// Configuration and identification register block with AXI4-Lite slave
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sysconf_defines.svh"

module sysconf_regs
  import sysconf_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1,      // Arbitrary value
  parameter logic [27:0] DEVICE_CODE = 28'h0abcdef, // Arbitrary value
  parameter logic [63:0] SERIAL = 64'h0123456789abcdef // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sram_req_t sram_req,
  input wire logic cpu_in_irq,
  input wire logic sleep_active,
  output sram_req_t sram_grant,
  output logic capture_alt_timebase,
  output logic compare_alt_timebase,
  output logic usb_phy_clock_en,
  output logic [31:0] peripheral_pin_routing,
  output logic [31:0] module_disable_regs,
  output logic [31:0] permission_group_regs
);

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] system_config_control_q;
  unlock_state_t unlock_q;
  config_ctl_t ctl;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // Latch address and data independently, in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  // Write response, always OKAY even when the write is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = `AXI_OKAY; // see [RQ13]

  // Byte-lane mask from strobes
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{wstrb_q[g]}};
    end
  endgenerate

  // ----------------------------------------
  // Unlock sequence: two keys in a row open one config write
  // ----------------------------------------
  logic unl_write;
  logic cfg_write;
  assign unl_write = wr_fire && awaddr_q == `OFF_UNLOCK && wstrb_q == 4'hf;
  assign cfg_write = wr_fire && awaddr_q == `OFF_CONFIG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_q <= unl_idle;
    end else if (unl_write) begin
      if (wdata_q == `UNLOCK_KEY1) begin
        unlock_q <= unl_key1;
      end else if (wdata_q == `UNLOCK_KEY2 && unlock_q == unl_key1) begin
        unlock_q <= unl_open; // see [RQ9]
      end else begin
        unlock_q <= unl_idle;
      end
    end else if (cfg_write) begin
      unlock_q <= unl_idle; // Any config write closes the window
    end
  end

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_config_control_q <= `CONFIG_RESET;
    end else if (cfg_write && unlock_q == unl_open) begin // see [RQ9] see [RQ13]
      system_config_control_q <= ((wdata_q & wmask) | (system_config_control_q & ~wmask))
        & `CONFIG_MASK; // see [RQ10]
    end
  end

  assign ctl.dma_sram_priority = system_config_control_q[`BIT_DMA_PRI];
  assign ctl.cpu_irq_sram_priority = system_config_control_q[`BIT_CPU_PRI];
  assign ctl.capture_alt_timebase = system_config_control_q[`BIT_CAP_ALT];
  assign ctl.compare_alt_timebase = system_config_control_q[`BIT_CMP_ALT];
  assign ctl.pin_route_lock = system_config_control_q[`BIT_ROUTE_LOCK];
  assign ctl.module_disable_lock = system_config_control_q[`BIT_MODDIS_LOCK];
  assign ctl.perm_group_lock = system_config_control_q[`BIT_PERM_LOCK];
  assign ctl.usb_sleep_clock_stop = system_config_control_q[`BIT_USB_STOP];

  // ----------------------------------------
  // Guarded peripheral registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peripheral_pin_routing <= `GUARDED_RESET;
    end else if (wr_fire && awaddr_q == `OFF_ROUTE && !ctl.pin_route_lock) begin // see [RQ5]
      peripheral_pin_routing <= (wdata_q & wmask) | (peripheral_pin_routing & ~wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_disable_regs <= `GUARDED_RESET;
    end else if (wr_fire && awaddr_q == `OFF_MODDIS && !ctl.module_disable_lock) begin // see [RQ6]
      module_disable_regs <= (wdata_q & wmask) | (module_disable_regs & ~wmask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permission_group_regs <= `GUARDED_RESET;
    end else if (wr_fire && awaddr_q == `OFF_PERMGRP && !ctl.perm_group_lock) begin // see [RQ7]
      permission_group_regs <= (wdata_q & wmask) | (permission_group_regs & ~wmask);
    end
  end

  // ----------------------------------------
  // SRAM arbitration: fixed priority when enabled, else round robin
  // ----------------------------------------
  logic [1:0] last_q;
  sram_req_t rr_grant;
  logic dma_hi;
  logic cpu_hi;
  assign dma_hi = ctl.dma_sram_priority && sram_req.dma; // see [RQ1]
  assign cpu_hi = ctl.cpu_irq_sram_priority && cpu_in_irq && sram_req.cpu; // see [RQ2]

  // Round robin among requesters, starting after the last served
  always_comb begin
    rr_grant = '0;
    case (last_q)
      2'd0: begin
        if (sram_req.cpu) rr_grant.cpu = 1'b1;
        else if (sram_req.other) rr_grant.other = 1'b1;
        else if (sram_req.dma) rr_grant.dma = 1'b1;
      end
      2'd1: begin
        if (sram_req.other) rr_grant.other = 1'b1;
        else if (sram_req.dma) rr_grant.dma = 1'b1;
        else if (sram_req.cpu) rr_grant.cpu = 1'b1;
      end
      default: begin
        if (sram_req.dma) rr_grant.dma = 1'b1;
        else if (sram_req.cpu) rr_grant.cpu = 1'b1;
        else if (sram_req.other) rr_grant.other = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sram_grant <= '0;
    end else if (dma_hi) begin
      sram_grant <= '{dma: 1'b1, cpu: 1'b0, other: 1'b0}; // see [RQ1]
    end else if (cpu_hi) begin
      sram_grant <= '{dma: 1'b0, cpu: 1'b1, other: 1'b0}; // see [RQ2]
    end else begin
      sram_grant <= rr_grant;
    end
  end

  // Remember who was served last
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= 2'd2;
    end else if (dma_hi || (!cpu_hi && rr_grant.dma)) begin
      last_q <= 2'd0;
    end else if (cpu_hi || rr_grant.cpu) begin
      last_q <= 2'd1;
    end else if (rr_grant.other) begin
      last_q <= 2'd2;
    end
  end

  // ----------------------------------------
  // Timebase selects and USB PHY clock gate
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_alt_timebase <= 1'b0;
      compare_alt_timebase <= 1'b0;
    end else begin
      capture_alt_timebase <= ctl.capture_alt_timebase; // see [RQ3]
      compare_alt_timebase <= ctl.compare_alt_timebase; // see [RQ4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_phy_clock_en <= 1'b1;
    end else begin
      usb_phy_clock_en <= !(ctl.usb_sleep_clock_stop && sleep_active); // see [RQ8]
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      `OFF_CONFIG: rd_mux = system_config_control_q & `CONFIG_MASK; // see [RQ10]
      `OFF_DEVCODE: rd_mux = {REVISION, DEVICE_CODE}; // see [RQ11]
      `OFF_SERIAL0: rd_mux = SERIAL[31:0]; // see [RQ12]
      `OFF_SERIAL1: rd_mux = SERIAL[63:32]; // see [RQ12]
      `OFF_ROUTE: rd_mux = peripheral_pin_routing;
      `OFF_MODDIS: rd_mux = module_disable_regs;
      `OFF_PERMGRP: rd_mux = permission_group_regs;
      `OFF_STATUS: rd_mux = {30'h00000000, unlock_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = `AXI_OKAY;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  dma_first_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ1]
    ctl.dma_sram_priority && sram_req.dma |=> sram_grant.dma)
    else $error("DMA priority not honoured");
  cpu_irq_first_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ2]
    ctl.cpu_irq_sram_priority && cpu_in_irq && sram_req.cpu && !dma_hi |=> sram_grant.cpu)
    else $error("CPU interrupt priority not honoured");
  cap_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ3]
    $changed(ctl.capture_alt_timebase) |=> capture_alt_timebase == $past(ctl.capture_alt_timebase))
    else $error("Capture timebase select wrong");
  cmp_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ4]
    ##1 compare_alt_timebase == $past(ctl.compare_alt_timebase))
    else $error("Compare timebase select wrong");
  route_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ5]
    ctl.pin_route_lock |=> $stable(peripheral_pin_routing))
    else $error("Locked pin routing changed");
  moddis_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ6]
    ctl.module_disable_lock |=> $stable(module_disable_regs))
    else $error("Locked module disable changed");
  perm_lock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ7]
    ctl.perm_group_lock |=> $stable(permission_group_regs))
    else $error("Locked permission group changed");
  usb_stop_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ8]
    ctl.usb_sleep_clock_stop && sleep_active |=> !usb_phy_clock_en)
    else $error("USB clock not stopped in sleep");
  unlock_need_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ9]
    unlock_q != unl_open |=> $stable(system_config_control_q))
    else $error("Config changed without unlock");
  unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ10]
    (system_config_control_q & ~`CONFIG_MASK) == 32'h00000000)
    else $error("Unimplemented config bit set");
  id_read_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ11]
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_DEVCODE
    |=> s_axi_rvalid && s_axi_rdata == {REVISION, DEVICE_CODE})
    else $error("Identification read wrong");
  serial_hi_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ12]
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFF_SERIAL1
    |=> s_axi_rdata == SERIAL[63:32])
    else $error("Serial word 1 read wrong");
  silent_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [RQ13]
    wr_fire |=> s_axi_bvalid && s_axi_bresp == `AXI_OKAY)
    else $error("Write response missing or not OKAY");

  cfg_written_c: cover property (@(posedge aclk) disable iff (!aresetn)
    cfg_write && unlock_q == unl_open);
  route_blocked_c: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && awaddr_q == `OFF_ROUTE && ctl.pin_route_lock);
  usb_stopped_c: cover property (@(posedge aclk) disable iff (!aresetn) !usb_phy_clock_en);

endmodule : sysconf_regs

/* verif/sysconf_regs_tb_top.sv */
// Self-checking testbench for the configuration and identification register block
`timescale 1ns/1ps
`include "sysconf_defines.svh"

module sysconf_regs_tb_top import sysconf_pkg::*;;
  localparam logic [3:0] REV = 4'h5; // Arbitrary value
  localparam logic [27:0] CODE = 28'h1234567; // Arbitrary value
  localparam logic [63:0] SER = 64'h0f1e2d3c4b5a6978; // Arbitrary value

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sram_req_t sram_req = 3'b000;
  sram_req_t sram_grant;
  logic cpu_in_irq = 1'b0;
  logic sleep_active = 1'b0;
  logic cap_alt, cmp_alt, usb_en;
  logic [31:0] route_q, moddis_q, perm_q;
  logic [31:0] cfg = 32'h0;
  logic [31:0] g_exp [3];
  int fails = 0;
  int n_checks = 0;

  // ----------------------------------------
  // Clock and device under test
  // ----------------------------------------
  initial begin
    forever #50 aclk = ~aclk;
  end

  sysconf_regs #(.REVISION(REV), .DEVICE_CODE(CODE), .SERIAL(SER)) sysconf_regs_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .sram_req(sram_req), .cpu_in_irq(cpu_in_irq),
    .sleep_active(sleep_active), .sram_grant(sram_grant),
    .capture_alt_timebase(cap_alt), .compare_alt_timebase(cmp_alt),
    .usb_phy_clock_en(usb_en), .peripheral_pin_routing(route_q),
    .module_disable_regs(moddis_q), .permission_group_regs(perm_q)
  );

  // ----------------------------------------
  // Comparison and closing tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_grant(input sram_req_t got, input sram_req_t exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: grant got %b expected %b", $time, got, exp);
    end
  endtask : chk_grant

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit a_ok;
    bit w_ok;
    n = 0;
    a_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!a_ok && awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(a_ok && w_ok) && n < 100);
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      $display("mismatch at %0t: write response timed out", $time);
    end
    chk_word({30'h0, bresp}, 32'h0);
  endtask : wr

  // Read: address held until taken, data captured at the valid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    if (n >= 100) begin
      fails++;
      $display("mismatch at %0t: read data timed out", $time);
    end
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk_word(d, exp);
    chk_word({30'h0, rresp}, 32'h0);
  endtask : rd_chk

  // Unlock, then write the configuration word
  task automatic set_cfg(input logic [31:0] v);
    wr(`OFF_UNLOCK, `UNLOCK_KEY1);
    wr(`OFF_UNLOCK, `UNLOCK_KEY2);
    wr(`OFF_CONFIG, v);
    cfg = v & `CONFIG_MASK;
  endtask : set_cfg

  function automatic logic [31:0] gport(input int i);
    return i == 0 ? route_q : (i == 1 ? moddis_q : perm_q);
  endfunction : gport

  // Expected grant where priority or a lone request makes it certain
  function automatic bit exp_grant(input sram_req_t r, output sram_req_t g);
    g = 3'b000;
    if (cfg[`BIT_DMA_PRI] && r.dma) g = 3'b100;
    else if (cfg[`BIT_CPU_PRI] && cpu_in_irq && r.cpu) g = 3'b010;
    else if ($countones(r) == 1) g = r;
    return g != 3'b000;
  endfunction : exp_grant

  // ----------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [31:0] v;
    logic [31:0] ro_exp [3];
    logic [7:0] ro_addr [3];
    logic [7:0] g_addr [3];
    int lock_bit [3];
    sram_req_t g;
    void'($urandom(32'h76fb));
    ro_exp = '{{REV, CODE}, SER[31:0], SER[63:32]};
    ro_addr = '{`OFF_DEVCODE, `OFF_SERIAL0, `OFF_SERIAL1};
    g_addr = '{`OFF_ROUTE, `OFF_MODDIS, `OFF_PERMGRP};
    lock_bit = '{`BIT_ROUTE_LOCK, `BIT_MODDIS_LOCK, `BIT_PERM_LOCK};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`OFF_CONFIG, `CONFIG_RESET);
    rd_chk(8'h40, 32'h0);
    rd_chk(`OFF_UNLOCK, 32'h0);
    chk_word({31'h0, usb_en}, 32'h1);
    // Config write without unlock is dropped
    wr(`OFF_CONFIG, 32'hffffffff);
    rd_chk(`OFF_CONFIG, 32'h0);
    // Broken key sequences keep the window shut; the status word tracks progress
    wr(`OFF_UNLOCK, `UNLOCK_KEY2);
    rd_chk(`OFF_STATUS, 32'h0);
    wr(`OFF_UNLOCK, `UNLOCK_KEY1);
    rd_chk(`OFF_STATUS, 32'h1);
    wr(`OFF_UNLOCK, 32'h0);
    wr(`OFF_UNLOCK, `UNLOCK_KEY2);
    rd_chk(`OFF_STATUS, 32'h0);
    wr(`OFF_CONFIG, 32'hffffffff);
    rd_chk(`OFF_CONFIG, 32'h0);
    wr(`OFF_UNLOCK, `UNLOCK_KEY1);
    wr(`OFF_UNLOCK, `UNLOCK_KEY2);
    rd_chk(`OFF_STATUS, 32'h2);
    wr(`OFF_CONFIG, 32'h0);
    rd_chk(`OFF_STATUS, 32'h0);
    // Read-only words survive writes
    for (int i = 0; i < 3; i++) begin
      rd_chk(ro_addr[i], ro_exp[i]);
      wr(ro_addr[i], $urandom);
      rd_chk(ro_addr[i], ro_exp[i]);
    end
    // Guarded registers writable while unlocked
    for (int i = 0; i < 3; i++) begin
      g_exp[i] = $urandom;
      rd_chk(g_addr[i], `GUARDED_RESET);
      wr(g_addr[i], g_exp[i]);
      rd_chk(g_addr[i], g_exp[i]);
      chk_word(gport(i), g_exp[i]);
    end
    // Configuration values: corners first, then random
    for (int i = 0; i < 14; i++) begin
      v = i == 0 ? 32'hffffffff : (i == 1 ? 32'h01000000 : $urandom);
      sram_req <= i < 2 ? 3'b111 : 3'($urandom);
      cpu_in_irq <= i < 2 ? 1'b1 : 1'($urandom);
      sleep_active <= 1'($urandom);
      set_cfg(v);
      rd_chk(`OFF_CONFIG, cfg);
      wr(`OFF_CONFIG, ~v);
      rd_chk(`OFF_CONFIG, cfg);
      repeat (2) @(posedge aclk);
      chk_word({30'h0, cap_alt, cmp_alt}, {30'h0, cfg[17], cfg[16]});
      chk_word({31'h0, usb_en}, {31'h0, !(cfg[8] && sleep_active)});
      if (exp_grant(sram_req, g)) chk_grant(sram_grant, g);
    end
    // Each lock refuses its registers, clearing it reopens them
    for (int i = 0; i < 3; i++) begin
      set_cfg(32'h1 << lock_bit[i]);
      v = $urandom;
      wr(g_addr[i], v);
      rd_chk(g_addr[i], g_exp[i]);
      chk_word(gport(i), g_exp[i]);
      set_cfg(32'h0);
      wr(g_addr[i], v);
      g_exp[i] = v;
      rd_chk(g_addr[i], g_exp[i]);
    end
    // Reset in mid-run returns the writable registers to their reset values
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`OFF_CONFIG, `CONFIG_RESET);
    rd_chk(`OFF_ROUTE, `GUARDED_RESET);
    rd_chk(`OFF_STATUS, 32'h0);
    chk_word({31'h0, usb_en}, 32'h1);
    conclude();
  end
endmodule : sysconf_regs_tb_top
